// File: logic/aims_pkg.sv
/*
 * constants, register map, pin routing tables and carrier types for the
 * converter input selection block.
 * assumes an 8-bit special-function-register bus and a 10-bit converter core.
 */
`default_nettype none

package aims_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] NEG_SEL_ADDR = 8'hba;
    localparam logic [7:0] POS_SEL_ADDR = 8'hbb;
    localparam int CODE_W = 5;
    localparam logic [CODE_W-1:0] CODE_RESET = 5'h00;
    localparam logic [2:0] UNUSED_READ = 3'h0;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ****************************************
    // channel codes
    // ****************************************
    localparam logic [CODE_W-1:0] LAST_PIN_CODE = 5'h14;
    localparam logic [CODE_W-1:0] POS_TEMP_CODE = 5'h1e;
    localparam logic [CODE_W-1:0] POS_SUPPLY_CODE = 5'h1f;
    localparam logic [CODE_W-1:0] NEG_VREF_CODE = 5'h1e;
    localparam logic [CODE_W-1:0] NEG_GND_CODE = 5'h1f;
    localparam logic [CODE_W-1:0] LARGE_RSVD_CODE = 5'h10;
    localparam int PIN_CODES = 21;
    localparam logic [5:0] NO_PIN = 6'h3f;

    // pin = port * 8 + bit
    localparam logic [5:0] PIN_MAP_SMALL [PIN_CODES] = '{
        6'h08, 6'h09, 6'h0a, 6'h0b, 6'h0c, 6'h0d, 6'h0e, 6'h0f, 6'h10, 6'h11, 6'h12,
        6'h13, 6'h14, 6'h15, 6'h16, 6'h17, 6'h18, 6'h00, 6'h01, 6'h04, 6'h05};
    localparam logic [5:0] PIN_MAP_LARGE [PIN_CODES] = '{
        6'h10, 6'h11, 6'h12, 6'h13, 6'h15, 6'h16, 6'h18, 6'h19, 6'h1c, 6'h1d, 6'h1f,
        6'h20, 6'h23, 6'h24, 6'h25, 6'h26, 6'h3f, 6'h03, 6'h04, 6'h09, 6'h0a};

    // ****************************************
    // converter timing and format
    // ****************************************
    localparam logic [1:0] TRACK_TICKS = 2'h3;
    localparam int RESULT_W = 10;
    localparam logic [RESULT_W-1:0] SIGN_FLIP = 10'h200;

    typedef enum logic [1:0] {
        AIMS_IDLE = 2'b00,
        AIMS_TRACK = 2'b01,
        AIMS_CONVERT = 2'b10
    } aims_state_t;

    // valid: code selects something; internal: temp/supply/vref/gnd source,
    // and then pin carries the selection code so the two sources stay apart
    typedef struct packed {
        logic valid;
        logic internal;
        logic [5:0] pin;
    } aims_route_t;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic [7:0] wdata;
    } aims_sfr_t;

    typedef struct packed {
        logic valid;
        logic is_signed;
        logic [RESULT_W-1:0] value;
    } aims_result_t;

endpackage : aims_pkg

`default_nettype wire

// File: logic/aims_top.sv
/*
 * channel select registers, input routing and the track/convert sequencer.
 * assumes the sfr bus, start pulse, converter clock tick and core handshake
 * all come from logic on clk.
 */
`timescale 1ns/100ps
`default_nettype none

module aims_top #(
    parameter bit LARGE_PACKAGE = 1'b0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register bus
    input wire aims_pkg::aims_sfr_t sfr,
    output logic [7:0] sfr_rdata,
    // conversion control
    input wire logic low_power_track_select,
    input wire logic start_conv,
    input wire logic sar_tick,
    output logic busy,
    // analog input mux steering
    output aims_pkg::aims_route_t pos_route,
    output aims_pkg::aims_route_t neg_route,
    output logic differential,
    output logic track,
    // converter core
    output logic conv_go,
    input wire logic core_done,
    input wire logic [aims_pkg::RESULT_W-1:0] core_result,
    output aims_pkg::aims_result_t result
);
    import aims_pkg::*;

    // ****************************************
    // routing decode
    // ****************************************
    function automatic aims_route_t route_of(input logic [CODE_W-1:0] code,
                                             input logic is_pos);
        aims_route_t r;
        logic [5:0] pin;
        logic [CODE_W-1:0] low_src;
        logic [CODE_W-1:0] high_src;
        r = '0;
        r.pin = NO_PIN;
        pin = NO_PIN;
        // 11110/11111 mean temp/supply on the positive side, vref/gnd on the negative
        low_src = is_pos ? POS_TEMP_CODE : NEG_VREF_CODE;
        high_src = is_pos ? POS_SUPPLY_CODE : NEG_GND_CODE;
        if (code <= LAST_PIN_CODE) begin
            // the tables only cover pin codes, so they are never indexed past their end
            pin = LARGE_PACKAGE ? PIN_MAP_LARGE[code] : PIN_MAP_SMALL[code];
            r.pin = pin;
            r.valid = (pin != NO_PIN);
        end else if (code == low_src || code == high_src) begin
            r.valid = 1'b1;
            r.internal = 1'b1;
            r.pin = {1'b0, code};
        end
        return r;
    endfunction : route_of

    // ****************************************
    // channel registers
    // ****************************************
    logic [CODE_W-1:0] pos_code;
    logic [CODE_W-1:0] neg_code;
    logic [CODE_W-1:0] next_pos_code;
    logic [CODE_W-1:0] next_neg_code;
    logic [7:0] next_sfr_rdata;

    always_comb begin
        next_pos_code = pos_code;
        next_neg_code = neg_code;
        // upper bits of the write are dropped
        if (sfr.wr && sfr.addr == POS_SEL_ADDR) begin
            next_pos_code = sfr.wdata[CODE_W-1:0];
        end
        if (sfr.wr && sfr.addr == NEG_SEL_ADDR) begin
            next_neg_code = sfr.wdata[CODE_W-1:0];
        end
        unique case (sfr.addr)
            POS_SEL_ADDR: next_sfr_rdata = {UNUSED_READ, pos_code};
            NEG_SEL_ADDR: next_sfr_rdata = {UNUSED_READ, neg_code};
            default: next_sfr_rdata = UNMAPPED_READ;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pos_code <= CODE_RESET;
            neg_code <= CODE_RESET;
            sfr_rdata <= UNMAPPED_READ;
        end else begin
            pos_code <= next_pos_code;
            neg_code <= next_neg_code;
            sfr_rdata <= next_sfr_rdata;
        end
    end

    // mux follows the registers at once; settling is software's wait
    assign pos_route = route_of(pos_code, 1'b1);
    assign neg_route = route_of(neg_code, 1'b0);
    assign differential = (neg_code != NEG_GND_CODE);

    // ****************************************
    // track and convert sequencer
    // ****************************************
    aims_state_t state;
    aims_state_t next_state;
    logic [1:0] track_cnt;
    logic [1:0] next_track_cnt;
    logic conv_lp;
    logic next_conv_lp;
    logic conv_diff;
    logic next_conv_diff;
    logic next_conv_go;
    aims_result_t next_result;

    always_comb begin
        next_state = state;
        next_track_cnt = track_cnt;
        next_conv_lp = conv_lp;
        next_conv_diff = conv_diff;
        next_conv_go = 1'b0;
        next_result = result;
        next_result.valid = 1'b0;
        unique case (state)
            AIMS_IDLE: begin
                // mode is frozen at start so a mid-conversion change cannot corrupt it
                if (start_conv) begin
                    next_conv_lp = low_power_track_select;
                    next_conv_diff = differential;
                    next_track_cnt = '0;
                    if (low_power_track_select) begin
                        next_state = AIMS_TRACK;
                    end else begin
                        next_state = AIMS_CONVERT;
                        next_conv_go = 1'b1;
                    end
                end
            end
            AIMS_TRACK: begin
                if (sar_tick) begin
                    if (track_cnt == TRACK_TICKS - 2'h1) begin
                        next_state = AIMS_CONVERT;
                        next_conv_go = 1'b1;
                    end else begin
                        next_track_cnt = track_cnt + 2'h1;
                    end
                end
            end
            AIMS_CONVERT: begin
                if (core_done) begin
                    next_state = AIMS_IDLE;
                    next_result.valid = 1'b1;
                    next_result.is_signed = conv_diff;
                    // core code is offset binary; flipping the msb gives two's complement
                    next_result.value = conv_diff ? (core_result ^ SIGN_FLIP) : core_result;
                end
            end
            default: next_state = AIMS_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= AIMS_IDLE;
            track_cnt <= 2'h0;
            conv_lp <= 1'b0;
            conv_diff <= 1'b0;
            conv_go <= 1'b0;
            result <= '0;
        end else begin
            state <= next_state;
            track_cnt <= next_track_cnt;
            conv_lp <= next_conv_lp;
            conv_diff <= next_conv_diff;
            conv_go <= next_conv_go;
            result <= next_result;
        end
    end

    // continuous tracking outside conversions unless low power is selected
    assign track = (state == AIMS_TRACK) ||
                   (state == AIMS_IDLE && !low_power_track_select);
    assign busy = (state != AIMS_IDLE);

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_lp_three_ticks: assert property (conv_go && conv_lp |->
        $past(state) == AIMS_TRACK && $past(track_cnt) == 2'h2 && $past(sar_tick))
        else $error("low-power tracking did not last three ticks");
    a_lp_enter_track: assert property (state == AIMS_IDLE && start_conv &&
        low_power_track_select |=> state == AIMS_TRACK && track && !conv_go)
        else $error("low-power start did not begin tracking");
    a_normal_direct: assert property (state == AIMS_IDLE && start_conv &&
        !low_power_track_select |=> conv_go && !track && state == AIMS_CONVERT)
        else $error("normal start did not convert at once");
    a_idle_tracks: assert property (state == AIMS_IDLE |->
        track == !low_power_track_select)
        else $error("idle tracking wrong for mode");
    a_convert_holds: assert property (state == AIMS_CONVERT |-> !track)
        else $error("tracking during conversion");
    a_mode_select: assert property ((neg_code == NEG_GND_CODE |-> !differential &&
        neg_route.internal) and (neg_code != NEG_GND_CODE |-> differential))
        else $error("single-ended or differential mode wrong");
    a_pos_write: assert property (sfr.wr && sfr.addr == POS_SEL_ADDR |=>
        pos_code == $past(sfr.wdata[4:0]))
        else $error("positive select write lost");
    a_neg_write: assert property (sfr.wr && sfr.addr == NEG_SEL_ADDR |=>
        neg_code == $past(sfr.wdata[4:0]))
        else $error("negative select write lost");
    a_read_upper: assert property ($past(sfr.addr) == POS_SEL_ADDR && !$past(rst) |->
        sfr_rdata == {3'h0, $past(pos_code)})
        else $error("positive select readback wrong");
    a_result_fmt: assert property (state == AIMS_CONVERT && core_done |=>
        result.valid && result.is_signed == $past(conv_diff) &&
        result.value == ($past(conv_diff) ? $past(core_result) ^ 10'h200 : $past(core_result)))
        else $error("result format wrong");
    a_reserved_map: assert property ((LARGE_PACKAGE && pos_code == 5'h10) ||
        (pos_code > 5'h14 && pos_code < 5'h1e) |-> !pos_route.valid)
        else $error("reserved code routed");

    c_lp_conv: cover property (state == AIMS_TRACK ##1 state == AIMS_CONVERT ##[1:100]
        result.valid);
    c_norm_conv: cover property (conv_go && !conv_lp);
    c_diff_result: cover property (result.valid && result.is_signed);

endmodule : aims_top

`default_nettype wire

// File: verification/aims_core_model.sv
/*
 * behavioural converter core: free-running converter clock ticks and a
 * result handshake after a chosen latency.
 * assumes conv_go is a one-cycle pulse on clk.
 */
`timescale 1ns/100ps
`default_nettype none

module aims_core_model #(
    parameter int DIV = 5
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // stimulus from the bench
    input wire logic [7:0] latency,
    input wire logic [aims_pkg::RESULT_W-1:0] sample,
    // core side of the handshake
    input wire logic conv_go,
    output logic sar_tick,
    output logic core_done,
    output logic [aims_pkg::RESULT_W-1:0] core_result
);
    import aims_pkg::*;
    int div_cnt;
    int wait_cnt;

    // ****************************************
    // converter clock and conversion
    // ****************************************
    // converter clock runs free; result bus toggles whenever it is not valid
    always_ff @(posedge clk) begin
        if (rst) begin
            div_cnt <= 0;
            sar_tick <= 1'b0;
            wait_cnt <= -1;
            core_done <= 1'b0;
            core_result <= 10'h155;
        end else begin
            div_cnt <= (div_cnt == DIV - 1) ? 0 : div_cnt + 1;
            sar_tick <= (div_cnt == DIV - 1);
            core_done <= (wait_cnt == 0);
            core_result <= (wait_cnt == 0) ? sample : ~core_result;
            if (conv_go) begin
                wait_cnt <= int'(latency);
            end else if (wait_cnt >= 0) begin
                wait_cnt <= wait_cnt - 1;
            end
        end
    end
endmodule : aims_core_model

`default_nettype wire

// File: verification/tb_top.sv
/*
 * self-checking bench: register access, routing, mode and conversions.
 * assumes the design on a 4 ns clock; one copy per pin map, both on one bus.
 */
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    import aims_pkg::*;
    localparam bit LARGE = 1'b1;
    localparam logic [4:0] CORNER [8] = '{5'h00, 5'h10, 5'h14, 5'h15, 5'h1d, 5'h1e, 5'h1f, 5'h0a};
    logic clk = 1'b0;
    logic rst = 1'b1;
    aims_sfr_t sfr = '0;
    logic [7:0] sfr_rdata;
    logic low_power_track_select = 1'b0;
    logic start_conv = 1'b0;
    logic sar_tick, busy, differential, track, conv_go, core_done;
    aims_route_t pos_route, neg_route;
    aims_route_t pos_route_s, neg_route_s;
    logic [RESULT_W-1:0] core_result;
    aims_result_t result;
    logic [7:0] latency = 8'h00;
    logic [RESULT_W-1:0] sample = '0;
    logic [4:0] neg_code = 5'h00;
    int seed = 32'h511c5fed;
    int n_fail = 0;
    int checked = 0;

    always #2 clk = ~clk;

    aims_top #(.LARGE_PACKAGE(LARGE)) dut (.clk(clk), .rst(rst), .sfr(sfr),
        .sfr_rdata(sfr_rdata), .low_power_track_select(low_power_track_select),
        .start_conv(start_conv), .sar_tick(sar_tick), .busy(busy), .pos_route(pos_route),
        .neg_route(neg_route), .differential(differential), .track(track),
        .conv_go(conv_go), .core_done(core_done), .core_result(core_result), .result(result));

    // small pin map copy: only its routing is compared, it runs in step with dut
    aims_top #(.LARGE_PACKAGE(1'b0)) dut_small (.clk(clk), .rst(rst), .sfr(sfr), .sfr_rdata(),
        .low_power_track_select(low_power_track_select), .start_conv(start_conv),
        .sar_tick(sar_tick), .busy(), .pos_route(pos_route_s), .neg_route(neg_route_s),
        .differential(), .track(), .conv_go(), .core_done(core_done),
        .core_result(core_result), .result());

    aims_core_model #(.DIV(5)) core (.clk(clk), .rst(rst), .latency(latency), .sample(sample),
        .conv_go(conv_go), .sar_tick(sar_tick), .core_done(core_done), .core_result(core_result));

    // ****************************************
    // checking and bus tasks
    // ****************************************
    task automatic final_report;
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : final_report

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic bound(input int n, input int lim);
        if (n >= lim) begin
            n_fail++;
            final_report();
        end
    endtask : bound

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr <= aims_sfr_t'{a, 1'b1, d};
        @(posedge clk);
        sfr.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        sfr.addr <= a;
        @(posedge clk);
        #1;
        chk(16'(sfr_rdata), 16'(exp));
    endtask : rd

    // pin codes route to the package map, internal sources flag internal
    task automatic chk_route(input aims_route_t r, input logic [4:0] c, input bit lg);
        logic ok;
        logic [5:0] pin;
        ok = (c <= LAST_PIN_CODE && !(lg && c == LARGE_RSVD_CODE)) || c >= POS_TEMP_CODE;
        pin = (c <= LAST_PIN_CODE) ? (lg ? PIN_MAP_LARGE[c] : PIN_MAP_SMALL[c]) : {1'b0, c};
        chk(16'(r.valid), 16'(ok));
        chk(16'(r.internal), 16'(ok && c >= POS_TEMP_CODE));
        chk(16'(r.pin), 16'(ok ? pin : NO_PIN));
    endtask : chk_route

    task automatic conv(input logic lp, input logic dup);
        int ticks;
        int n;
        logic [RESULT_W-1:0] smp;
        ticks = 0;
        smp = RESULT_W'($random(seed));
        @(posedge clk);
        low_power_track_select <= lp;
        sample <= smp;
        latency <= 8'($random(seed) & 15);
        // settle time after a channel change before starting
        repeat (4) @(posedge clk);
        #1;
        chk(16'(track), 16'(!lp));
        @(posedge clk);
        start_conv <= 1'b1;
        @(posedge clk);
        start_conv <= 1'b0;
        for (n = 0; n < 200 && conv_go !== 1'b1; n++) begin
            @(negedge clk);
            if (track === 1'b1 && busy === 1'b1 && sar_tick === 1'b1) ticks++;
        end
        bound(n, 200);
        chk(16'(ticks), lp ? 16'h0003 : 16'h0000);
        chk(16'(track), 16'h0000);
        if (dup) begin
            @(posedge clk);
            start_conv <= 1'b1;
            @(posedge clk);
            start_conv <= 1'b0;
        end
        for (n = 0; n < 100 && result.valid !== 1'b1; n++) @(negedge clk);
        bound(n, 100);
        chk(16'(result.is_signed), 16'(neg_code != NEG_GND_CODE));
        chk(16'(result.value), 16'((neg_code != NEG_GND_CODE) ? smp ^ SIGN_FLIP : smp));
        @(negedge clk);
        chk(16'({busy, conv_go}), 16'h0000);
    endtask : conv

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        logic [4:0] pc;
        logic [7:0] d;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd(NEG_SEL_ADDR, 8'h00);
        rd(POS_SEL_ADDR, 8'h00);
        chk(16'(differential), 16'h0001);
        for (int i = 0; i < 28; i++) begin
            pc = (i < 8) ? CORNER[i] : 5'($random(seed));
            d = 8'($random(seed));
            neg_code = (i < 8) ? CORNER[7 - i] : d[4:0];
            wr(POS_SEL_ADDR, {3'b111, pc});
            rd(POS_SEL_ADDR, {3'h0, pc});
            wr(NEG_SEL_ADDR, d & 8'he0 | 8'(neg_code));
            rd(NEG_SEL_ADDR, {3'h0, neg_code});
            chk_route(pos_route, pc, LARGE);
            chk_route(neg_route, neg_code, LARGE);
            chk_route(pos_route_s, pc, 1'b0);
            chk_route(neg_route_s, neg_code, 1'b0);
            chk(16'(differential), 16'(neg_code != NEG_GND_CODE));
            conv(i[0], i[1]);
        end
        wr(8'hbc, 8'hff);
        rd(8'hbc, UNMAPPED_READ);
        rd(NEG_SEL_ADDR, {3'h0, neg_code});
        final_report();
    end
endmodule : tb_top

`default_nettype wire
